// *** hdl/vcz_cal_div.sv ***
// Reference-to-calibration clock divider: R counter then calibration divider
`timescale 1ns/1ns
module vcz_cal_div #(
  parameter int R_W = 10
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic ref_edge,
  input wire logic [R_W-1:0] r_div,
  input wire logic [1:0] cal_sel,
  // Calibration clock tick
  output logic cal_tick
);
  if (R_W != 10) begin : g_chk
    $error("vcz_cal_div supports R_W of 10 only");
  end

  vcz_pkg::vcz_div_st_t q, d;
  logic [9:0] r_last;
  logic [3:0] c_last;

  ////////////////////////////////////////////////////////////////////////////
  // Ratio decode: 2, 4, 8 or 16
  assign c_last = 4'((5'h02 << cal_sel) - 5'h01);
  // An R of zero is served as divide-by-one
  assign r_last = (r_div == 10'h000) ? 10'h000 : r_div - 10'h001;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!run) begin
      d.r_cnt = 10'h000;
      d.c_cnt = 4'h0;
    end else if (ref_edge) begin
      if (q.r_cnt >= r_last) begin
        d.r_cnt = 10'h000;
        if (q.c_cnt >= c_last) begin
          d.c_cnt = 4'h0;
          d.tick = 1'b1;
        end else begin
          d.c_cnt = q.c_cnt + 4'h1;
        end
      end else begin
        d.r_cnt = q.r_cnt + 10'h001;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign cal_tick = q.tick;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  tick_single_a: assert property (ce && cal_tick |=> !cal_tick)
    else $error("calibration tick lasted more than one cycle");
  tick_needs_run_a: assert property (ce && !run |=> !cal_tick)
    else $error("calibration tick while divider stopped");
endmodule : vcz_cal_div

// *** hdl/vcz_pkg.sv ***
// Shared constants and carrier types for the calibration and zero-delay block
package vcz_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PLL_CTRL = 10'h018;
  localparam logic [9:0] IDX_ZD_CTRL = 10'h01E;
  localparam logic [9:0] IDX_STATUS = 10'h01F;
  localparam logic [9:0] IDX_VCO_DIV = 10'h1E0;
  localparam logic [9:0] IDX_UPDATE = 10'h232;
  localparam logic [9:0] IDX_R_DIV = 10'h0F0;
  localparam logic [9:0] IDX_DELAYS = 10'h0F1;
  // Field positions
  localparam int POS_CAL_START = 0;
  localparam int POS_CAL_DIV = 1;
  localparam int POS_ZD_MODE = 1;
  localparam int POS_FB_CHAN = 3;
  localparam int POS_CAL_DONE = 6;
  localparam int POS_UPDATE = 0;
  localparam int POS_VCO_DIV = 0;
  localparam int POS_R_DIV = 0;
  localparam int POS_REF_DLY = 0;
  localparam int POS_FB_DLY = 8;
  // Field encodings
  localparam logic [1:0] ZD_INTERNAL = 2'h1;
  localparam logic [1:0] ZD_EXTERNAL = 2'h3;
  // Reset values
  localparam logic [1:0] RST_CAL_DIV = 2'h3;
  localparam logic [1:0] RST_ZD_MODE = 2'h0;
  localparam logic [1:0] RST_FB_CHAN = 2'h0;
  localparam logic [2:0] RST_VCO_DIV = 3'h0;
  localparam logic [9:0] RST_R_DIV = 10'h001;
  localparam logic [3:0] RST_DLY = 4'h0;
  // Calibration length in calibration-clock cycles
  localparam logic [12:0] CAL_CYCLES = 13'h1130;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {CAL_IDLE, CAL_RUN} vcz_cal_st_t;

  // Software-visible configuration, held as shadow and as active copy
  typedef struct packed {
    logic cal_start;
    logic [1:0] cal_div;
    logic [1:0] zd_mode;
    logic [1:0] fb_chan;
    logic [2:0] vco_div;
    logic [9:0] r_div;
    logic [3:0] ref_dly;
    logic [3:0] fb_dly;
  } vcz_cfg_t;

  // Divider state
  typedef struct packed {
    logic [9:0] r_cnt;
    logic [3:0] c_cnt;
    logic tick;
  } vcz_div_st_t;

  // Top-level state
  typedef struct packed {
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic al_s1;
    logic al_s2;
    logic al_s3;
    logic awv;
    logic [9:0] aw_idx;
    logic wv;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    vcz_cfg_t sh;
    vcz_cfg_t ac;
    vcz_cal_st_t cal;
    logic [12:0] cal_cnt;
    logic out_sync;
    logic cal_done;
    logic loop_closed;
    logic zd_en;
    logic mux_a_ext;
    logic mux_b_zd;
    logic [1:0] fb_chan;
  } vcz_st_t;
endpackage : vcz_pkg

// *** hdl/vcz_top.sv ***
// Oscillator calibration sequencer and zero-delay feedback select, AXI4-Lite slave
// Functional notes
// - Calibration clock is reference divided by R, then by the calibration divider.
// - Autoload-then-calibrate at power-up starts calibration without software.
// - Status bit reads one once the calibration sequence has finished.
// - Calibration asserts output sync; at the end it releases sync and closes the loop in the same cycle.
// - Sync is released at calibration end without waiting for lock.
// - Two-bit field picks the phase-detector divide ratio for calibration clock.
// - Calibration lasts a fixed count of calibration-clock cycles.
// - Divider register changes never start a calibration by themselves.
// - Mode field 01b selects internal, 11b external zero-delay feedback.
// - Internal mode feeds channel divider 0 back through both feedback muxes.
// - External mode feeds the returned output through both muxes to N.
// - Programmable delays exist in reference and feedback paths.
`timescale 1ns/1ns
module vcz_top #(
  parameter int R_W = 10
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  // Pins from outside the clock domain
  input wire logic REF_CLK_IN,
  input wire logic AUTOLOAD_CAL,
  // AXI4-Lite write address and data
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Calibration status toward the analog and distribution sections
  output logic OUT_SYNC,
  output logic CAL_DONE,
  output logic LOOP_CLOSED,
  output logic [2:0] VCO_DIV,
  // Feedback path control
  output logic ZD_EN,
  output logic FEEDBACK_SELECT_MUX_A,
  output logic FEEDBACK_SELECT_MUX_B,
  output logic [1:0] FB_CHAN,
  output logic [3:0] REF_DLY,
  output logic [3:0] FB_DLY
);
  if (R_W != 10) begin : g_chk
    $error("vcz_top supports R_W of 10 only");
  end

  vcz_pkg::vcz_st_t q, d;
  logic cal_tick;
  logic ref_edge;
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // Register image for reads and byte-lane merges
  function automatic logic [31:0] reg_img(input vcz_pkg::vcz_cfg_t c, input logic [9:0] idx,
                                          input logic done);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (idx == vcz_pkg::IDX_PLL_CTRL) begin
      v[vcz_pkg::POS_CAL_START] = c.cal_start;
      v[vcz_pkg::POS_CAL_DIV +: 2] = c.cal_div;
    end else if (idx == vcz_pkg::IDX_ZD_CTRL) begin
      v[vcz_pkg::POS_ZD_MODE +: 2] = c.zd_mode;
      v[vcz_pkg::POS_FB_CHAN +: 2] = c.fb_chan;
    end else if (idx == vcz_pkg::IDX_STATUS) begin
      v[vcz_pkg::POS_CAL_DONE] = done;
    end else if (idx == vcz_pkg::IDX_VCO_DIV) begin
      v[vcz_pkg::POS_VCO_DIV +: 3] = c.vco_div;
    end else if (idx == vcz_pkg::IDX_R_DIV) begin
      v[vcz_pkg::POS_R_DIV +: 10] = c.r_div;
    end else if (idx == vcz_pkg::IDX_DELAYS) begin
      v[vcz_pkg::POS_REF_DLY +: 4] = c.ref_dly;
      v[vcz_pkg::POS_FB_DLY +: 4] = c.fb_dly;
    end
    return v;
  endfunction : reg_img

  function automatic logic is_mapped(input logic [9:0] idx);
    return idx == vcz_pkg::IDX_PLL_CTRL || idx == vcz_pkg::IDX_ZD_CTRL ||
           idx == vcz_pkg::IDX_STATUS || idx == vcz_pkg::IDX_VCO_DIV ||
           idx == vcz_pkg::IDX_UPDATE || idx == vcz_pkg::IDX_R_DIV ||
           idx == vcz_pkg::IDX_DELAYS;
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Edge of the synchronised reference; the first stage feeds only the second
  assign ref_edge = q.ref_s2 && !q.ref_s3;
  assign running = (q.cal == vcz_pkg::CAL_RUN);

  vcz_cal_div #(
    .R_W(R_W)
  ) u_div (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .ce(CE),
    .run(running),
    .ref_edge(ref_edge),
    .r_div(q.ac.r_div),
    .cal_sel(q.ac.cal_div),
    .cal_tick(cal_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: synchronisers, bus slave, update, sequencer, feedback
  always_comb begin
    logic [31:0] mask;
    logic [31:0] merged;
    logic do_wr;
    logic upd;
    logic trig;
    mask = 32'h0000_0000;
    merged = 32'h0000_0000;
    upd = 1'b0;
    trig = 1'b0;
    do_wr = 1'b0;
    d = q;
    // Pin synchronisers
    d.ref_s1 = REF_CLK_IN;
    d.ref_s2 = q.ref_s1;
    d.ref_s3 = q.ref_s2;
    d.al_s1 = AUTOLOAD_CAL;
    d.al_s2 = q.al_s1;
    d.al_s3 = q.al_s2;
    // Address and data may arrive in either order
    if (S_AXI_AWVALID && q.awrdy) begin
      d.awv = 1'b1;
      d.aw_idx = S_AXI_AWADDR[11:2];
    end
    if (S_AXI_WVALID && q.wrdy) begin
      d.wv = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    do_wr = q.awv && q.wv && !q.bvalid;
    if (do_wr) begin
      for (int i = 0; i < 4; i++) begin
        mask[i*8 +: 8] = {8{q.wstrb[i]}};
      end
      merged = (reg_img(q.sh, q.aw_idx, q.cal_done) & ~mask) | (q.wdata & mask);
      d.awv = 1'b0;
      d.wv = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(q.aw_idx) ? vcz_pkg::RESP_OKAY : vcz_pkg::RESP_SLVERR;
      // Writes land in the shadow copy; the update strobe makes them active
      if (q.aw_idx == vcz_pkg::IDX_PLL_CTRL) begin
        d.sh.cal_start = merged[vcz_pkg::POS_CAL_START];
        d.sh.cal_div = merged[vcz_pkg::POS_CAL_DIV +: 2];
      end else if (q.aw_idx == vcz_pkg::IDX_ZD_CTRL) begin
        d.sh.zd_mode = merged[vcz_pkg::POS_ZD_MODE +: 2];
        d.sh.fb_chan = merged[vcz_pkg::POS_FB_CHAN +: 2];
      end else if (q.aw_idx == vcz_pkg::IDX_VCO_DIV) begin
        d.sh.vco_div = merged[vcz_pkg::POS_VCO_DIV +: 3];
      end else if (q.aw_idx == vcz_pkg::IDX_R_DIV) begin
        d.sh.r_div = merged[vcz_pkg::POS_R_DIV +: 10];
      end else if (q.aw_idx == vcz_pkg::IDX_DELAYS) begin
        d.sh.ref_dly = merged[vcz_pkg::POS_REF_DLY +: 4];
        d.sh.fb_dly = merged[vcz_pkg::POS_FB_DLY +: 4];
      end else if (q.aw_idx == vcz_pkg::IDX_UPDATE) begin
        upd = merged[vcz_pkg::POS_UPDATE];
      end
    end
    // Read channel; status reads live state
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rdata = reg_img(q.ac, S_AXI_ARADDR[11:2], q.cal_done);
      d.rresp = is_mapped(S_AXI_ARADDR[11:2]) ? vcz_pkg::RESP_OKAY : vcz_pkg::RESP_SLVERR;
    end
    // Ready flags come from flops, so they follow the next occupancy
    d.awrdy = !d.awv && !d.bvalid;
    d.wrdy = !d.wv && !d.bvalid;
    d.arrdy = !d.rvalid;
    // update copies shadow; an update triggers only on a rising start bit
    if (upd) begin
      d.ac = q.sh;
    end
    // only the start edge or the autoload pin can trigger
    // autoload request starts calibration without software
    trig = (upd && q.sh.cal_start && !q.ac.cal_start) || (q.al_s2 && !q.al_s3);
    // Calibration sequencer
    case (q.cal)
      vcz_pkg::CAL_IDLE: begin
        if (trig) begin
          d.cal = vcz_pkg::CAL_RUN;
        end
      end
      vcz_pkg::CAL_RUN: begin
        // A fresh trigger restarts the count in the trigger block below
        if (!trig && cal_tick) begin
          if (q.cal_cnt == vcz_pkg::CAL_CYCLES - 13'h0001) begin
            d.cal = vcz_pkg::CAL_IDLE;
            // release sync without waiting for lock
            d.out_sync = 1'b0;
            d.cal_done = 1'b1;
            // loop closes once sync is released
            d.loop_closed = 1'b1;
          end else begin
            d.cal_cnt = q.cal_cnt + 13'h0001;
          end
        end
      end
      default: begin
        d.cal = vcz_pkg::CAL_IDLE;
      end
    endcase
    if (trig) begin
      d.cal_cnt = 13'h0000;
      d.out_sync = 1'b1;
      d.cal_done = 1'b0;
      d.loop_closed = 1'b0;
    end
    d.zd_en = (d.ac.zd_mode == vcz_pkg::ZD_INTERNAL) || (d.ac.zd_mode == vcz_pkg::ZD_EXTERNAL);
    // external mode takes the returned output through mux A
    d.mux_a_ext = (d.ac.zd_mode == vcz_pkg::ZD_EXTERNAL);
    d.mux_b_zd = d.zd_en;
    // internal mode always feeds back channel divider 0
    d.fb_chan = d.mux_a_ext ? d.ac.fb_chan : 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      q <= '0;
      q.sh.cal_div <= vcz_pkg::RST_CAL_DIV;
      q.sh.zd_mode <= vcz_pkg::RST_ZD_MODE;
      q.sh.fb_chan <= vcz_pkg::RST_FB_CHAN;
      q.sh.vco_div <= vcz_pkg::RST_VCO_DIV;
      q.sh.r_div <= vcz_pkg::RST_R_DIV;
      q.sh.ref_dly <= vcz_pkg::RST_DLY;
      q.sh.fb_dly <= vcz_pkg::RST_DLY;
      q.ac.cal_div <= vcz_pkg::RST_CAL_DIV;
      q.ac.zd_mode <= vcz_pkg::RST_ZD_MODE;
      q.ac.fb_chan <= vcz_pkg::RST_FB_CHAN;
      q.ac.vco_div <= vcz_pkg::RST_VCO_DIV;
      q.ac.r_div <= vcz_pkg::RST_R_DIV;
      q.ac.ref_dly <= vcz_pkg::RST_DLY;
      q.ac.fb_dly <= vcz_pkg::RST_DLY;
      q.cal <= vcz_pkg::CAL_IDLE;
    end else if (CE) begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign S_AXI_AWREADY = q.awrdy;
  assign S_AXI_WREADY = q.wrdy;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = q.arrdy;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign OUT_SYNC = q.out_sync;
  assign CAL_DONE = q.cal_done;
  assign LOOP_CLOSED = q.loop_closed;
  assign VCO_DIV = q.ac.vco_div;
  assign ZD_EN = q.zd_en;
  assign FEEDBACK_SELECT_MUX_A = q.mux_a_ext;
  assign FEEDBACK_SELECT_MUX_B = q.mux_b_zd;
  assign FB_CHAN = q.fb_chan;
  // delays in reference and feedback paths
  assign REF_DLY = q.ac.ref_dly;
  assign FB_DLY = q.ac.fb_dly;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic sw_trig;
  assign sw_trig = q.awv && q.wv && !q.bvalid && q.aw_idx == vcz_pkg::IDX_UPDATE &&
                   q.wstrb[0] && q.wdata[vcz_pkg::POS_UPDATE] && q.sh.cal_start &&
                   !q.ac.cal_start;

  sequence s_trigger;
    CE && sw_trig;
  endsequence
  sequence s_cal_held;
    OUT_SYNC && !CAL_DONE && !LOOP_CLOSED;
  endsequence
  sync_on_start_a: assert property (s_trigger |=> s_cal_held)
    else $error("trigger did not hold outputs static");
  done_cleared_a: assert property (s_trigger |=> !CAL_DONE)
    else $error("done bit not cleared at trigger");
  done_on_count_a: assert property ($rose(CAL_DONE) |->
      $past(q.cal_cnt) == vcz_pkg::CAL_CYCLES - 13'h0001 && $past(cal_tick))
    else $error("calibration ended at wrong count");
  sync_release_a: assert property ($fell(OUT_SYNC) |-> CAL_DONE && LOOP_CLOSED)
    else $error("sync released without completion");
  status_read_a: assert property (CE && S_AXI_ARVALID && S_AXI_ARREADY &&
      S_AXI_ARADDR[11:2] == vcz_pkg::IDX_STATUS |=> S_AXI_RDATA[6] == $past(CAL_DONE))
    else $error("status read does not show done");
  no_self_start_a: assert property (!running && !sw_trig && !(q.al_s2 && !q.al_s3)
      |=> !running)
    else $error("calibration began without request");
  autoload_start_a: assert property (CE && q.al_s2 && !q.al_s3 |=> running ##0 OUT_SYNC)
    else $error("autoload did not start calibration");
  internal_fb_a: assert property (q.ac.zd_mode == vcz_pkg::ZD_INTERNAL |->
      ZD_EN && !FEEDBACK_SELECT_MUX_A && FEEDBACK_SELECT_MUX_B && FB_CHAN == 2'h0)
    else $error("internal mode feedback path wrong");
  external_fb_a: assert property (q.ac.zd_mode == vcz_pkg::ZD_EXTERNAL |->
      FEEDBACK_SELECT_MUX_A && FEEDBACK_SELECT_MUX_B && FB_CHAN == q.ac.fb_chan)
    else $error("external mode feedback path wrong");
endmodule : vcz_top

// *** verif/vcz_top_tb.sv ***
// Self-checking bench for the calibration sequencer and zero-delay select
`timescale 1ns/1ns
module vcz_top_tb;
  ////////////////////////////////////////////////////////////////////////
  // Constants: byte addresses, responses, expected calibration length
  localparam logic [11:0] A_PLL = 12'(4 * vcz_pkg::IDX_PLL_CTRL);
  localparam logic [11:0] A_ZD = 12'(4 * vcz_pkg::IDX_ZD_CTRL);
  localparam logic [11:0] A_STAT = 12'(4 * vcz_pkg::IDX_STATUS);
  localparam logic [11:0] A_VCO = 12'(4 * vcz_pkg::IDX_VCO_DIV);
  localparam logic [11:0] A_UPD = 12'(4 * vcz_pkg::IDX_UPDATE);
  localparam logic [11:0] A_RDIV = 12'(4 * vcz_pkg::IDX_R_DIV);
  localparam logic [11:0] A_DLY = 12'(4 * vcz_pkg::IDX_DELAYS);
  localparam logic [1:0] OK = vcz_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = vcz_pkg::RESP_SLVERR;
  // R of one, divider code 00 (ratio 2): each run near 35k cycles
  localparam int CAL_REF = int'(vcz_pkg::CAL_CYCLES) * 1 * 2;
  localparam int CYC_MAX = 90000;
  ////////////////////////////////////////////////////////////////////////
  // Design ports
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic CE = 1'b1;
  logic REF_CLK_IN = 1'b0;
  logic AUTOLOAD_CAL = 1'b0;
  logic [11:0] S_AXI_AWADDR = 12'h000;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_AWREADY;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_WREADY;
  logic [1:0] S_AXI_BRESP;
  logic S_AXI_BVALID;
  logic S_AXI_BREADY = 1'b1;
  logic [11:0] S_AXI_ARADDR = 12'h000;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_ARREADY;
  logic [31:0] S_AXI_RDATA;
  logic [1:0] S_AXI_RRESP;
  logic S_AXI_RVALID;
  logic S_AXI_RREADY = 1'b1;
  logic OUT_SYNC, CAL_DONE, LOOP_CLOSED, ZD_EN, FEEDBACK_SELECT_MUX_A, FEEDBACK_SELECT_MUX_B;
  logic [2:0] VCO_DIV;
  logic [1:0] FB_CHAN;
  logic [3:0] REF_DLY, FB_DLY;
  // Bench state
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int ref_rises = 0;
  int ref_ph = 0;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];

  vcz_top dut_u (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .REF_CLK_IN(REF_CLK_IN),
    .AUTOLOAD_CAL(AUTOLOAD_CAL), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .OUT_SYNC(OUT_SYNC), .CAL_DONE(CAL_DONE), .LOOP_CLOSED(LOOP_CLOSED), .VCO_DIV(VCO_DIV),
    .ZD_EN(ZD_EN), .FEEDBACK_SELECT_MUX_A(FEEDBACK_SELECT_MUX_A),
    .FEEDBACK_SELECT_MUX_B(FEEDBACK_SELECT_MUX_B), .FB_CHAN(FB_CHAN), .REF_DLY(REF_DLY),
    .FB_DLY(FB_DLY)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock, reference at a quarter of it, and hang guard
  always #50 CLK_SYS = ~CLK_SYS;

  // Reference runs free; rising edges counted to time a calibration
  always @(posedge CLK_SYS) begin
    ref_ph <= ref_ph + 1;
    if (ref_ph % 2 == 1) begin
      REF_CLK_IN <= ~REF_CLK_IN;
      if (REF_CLK_IN == 1'b0) ref_rises <= ref_rises + 1;
    end
  end

  // Ceiling sits above two full calibrations plus register traffic
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      fail_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks and closing report
  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: bus got %h exp %h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: pins got %h exp %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Responses are taken off the queues in issue order as they appear
  always @(posedge CLK_SYS) begin
    if (S_AXI_BVALID === 1'b1 && S_AXI_BREADY === 1'b1)
      chk_bus({32'h0, S_AXI_BRESP}, exp_b.size() > 0 ? {32'h0, exp_b.pop_front()} : 'x);
    if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY === 1'b1)
      chk_bus({S_AXI_RRESP, S_AXI_RDATA}, exp_r.size() > 0 ? exp_r.pop_front() : 'x);
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus master tasks; each valid is held until its own ready edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
  endtask : rd

  task automatic upd();
    wr(A_UPD, 32'h1, OK);
  endtask : upd

  // Status stays low while busy; end must land within two reference edges
  task automatic wait_cal(input int t0);
    int n;
    while (OUT_SYNC === 1'b1) begin
      chk_out({30'h0, CAL_DONE, LOOP_CLOSED}, 32'h0);
      @(posedge CLK_SYS);
    end
    n = ref_rises - t0;
    chk_out({30'h0, CAL_DONE, LOOP_CLOSED}, 32'h3);
    chk_out(32'(n >= CAL_REF - 2 && n <= CAL_REF + 2), 32'h1);
    rd(A_STAT, 32'h1 << vcz_pkg::POS_CAL_DONE, OK);
  endtask : wait_cal

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin : main
    logic [1:0] modes[2];
    logic [1:0] fb;
    logic [7:0] dly;
    logic [2:0] vco;
    int t0;
    modes[0] = vcz_pkg::ZD_EXTERNAL;
    modes[1] = vcz_pkg::ZD_INTERNAL;
    void'($urandom(60));
    repeat (8) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    chk_out({27'h0, OUT_SYNC, CAL_DONE, LOOP_CLOSED, ZD_EN, FEEDBACK_SELECT_MUX_B},
            32'h0);
    rd(A_PLL, 32'({vcz_pkg::RST_CAL_DIV, 1'b0}), OK);
    rd(A_ZD, 32'h0, OK);
    rd(A_STAT, 32'h0, OK);
    rd(A_RDIV, 32'(vcz_pkg::RST_R_DIV), OK);
    rd(A_UPD, 32'h0, OK);
    rd(12'h004, 32'h0, ERR);
    wr(12'h004, 32'hFFFFFFFF, ERR);
    $display("done: reset values");
    // feedback modes, delays and divider take effect on update
    foreach (modes[i]) begin
      fb = 2'($urandom_range(3));
      dly = 8'($urandom);
      vco = 3'($urandom_range(5, 1));
      wr(A_ZD, 32'({fb, modes[i], 1'b0}), OK);
      wr(A_DLY, 32'({dly[7:4], 4'h0, dly[3:0]}), OK);
      wr(A_VCO, 32'(vco), OK);
      upd();
      repeat (2) @(posedge CLK_SYS);
      chk_out({16'h0, ZD_EN, FEEDBACK_SELECT_MUX_A, FEEDBACK_SELECT_MUX_B,
               FB_CHAN, REF_DLY, FB_DLY, VCO_DIV}, {16'h0, 1'b1, modes[i][1], 1'b1,
               modes[i][1] ? fb : 2'h0, dly[3:0], dly[7:4], vco});
      rd(A_ZD, 32'({fb, modes[i], 1'b0}), OK);
    end
    $display("done: feedback select");
    // first calibration: start bit with ratio 2, then update
    wr(A_PLL, 32'h1, OK);
    chk_out({31'h0, OUT_SYNC}, 32'h0);
    upd();
    t0 = ref_rises;
    repeat (2) @(posedge CLK_SYS);
    chk_out({29'h0, OUT_SYNC, CAL_DONE, LOOP_CLOSED}, 32'h4);
    rd(A_STAT, 32'h0, OK);
    wait_cal(t0);
    $display("done: first calibration");
    // divider change and repeated start do not calibrate
    wr(A_RDIV, 32'h1, OK);
    upd();
    wr(A_PLL, 32'h1, OK);
    upd();
    repeat (8) @(posedge CLK_SYS);
    chk_out({30'h0, OUT_SYNC, CAL_DONE}, 32'h1);
    $display("done: no self start");
    // autoload pin starts a calibration, held off while the clock enable is low
    CE <= 1'b0;
    AUTOLOAD_CAL <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    chk_out({30'h0, OUT_SYNC, CAL_DONE}, 32'h1);
    CE <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    chk_out({30'h0, OUT_SYNC, CAL_DONE}, 32'h2);
    wr(A_PLL, 32'h0, OK);
    upd();
    wr(A_PLL, 32'h1, OK);
    upd();
    t0 = ref_rises;
    repeat (2) @(posedge CLK_SYS);
    chk_out({30'h0, OUT_SYNC, CAL_DONE}, 32'h2);
    wait_cal(t0);
    $display("done: autoload and retrigger");
    finish_test();
  end
endmodule : vcz_top_tb
